// [testbench.sv]
// self-checking bench for the interrupt acknowledge block
`timescale 1ns/100ps
module testbench;
	typedef struct {
		logic [15:0] vec;
		int gap;
	} via_note_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] sfr_addr_i = 16'h0000;
	logic [2:0] sfr_bitpos_i = 3'h0;
	logic [7:0] sfr_wdata_i = 8'h00, stack_data_i = 8'h00, psw_wdata_i = 8'h00;
	logic [4:0] external_irq_pin_i = 5'h00;
	logic [23:0] irq_src_i = '0, request_flag_set_i = '0, request_flag_clr_i = '0;
	logic [23:0] mask_flag_i = '1, priority_flag_i = '1;
	logic sfr_wr_i = 1'b0, sfr_bit_i = 1'b0, nmi_req_i = 1'b0, break_instruction_i = 1'b0;
	logic return_from_irq_i = 1'b0, return_from_break_i = 1'b0, pop_psw_i = 1'b0;
	logic push_psw_i = 1'b0, psw_wr_i = 1'b0, slow = 1'b0, instr_boundary_i;
	logic [7:0] sfr_rdata_o, program_status_word_o, stack_data_o;
	logic [23:0] request_flag_o;
	logic cpu_hold_o, push_psw_o, push_pc_o, vec_load_o, nmi_active_o;
	logic [15:0] vector_o;
	int n_errors = 0, compares = 0, gap_cnt = 0;
	via_note_s exp_q[$];
	via_note_s cur;

	always #2.5 clk_i = ~clk_i;

	via_ack u_via_ack (.*);
	via_cpu_model u_via_cpu_model (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.slow_i(slow),
		.cpu_hold_i(cpu_hold_o),
		.instr_boundary_o(instr_boundary_i)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
		end
	endtask : check
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
		tick();
	endtask : pulse
	task automatic wr(input logic f, input logic b, input logic [2:0] pos, input logic [7:0] d);
		sfr_addr_i = f ? via_pkg::ADDR_FALL_SELECT : via_pkg::ADDR_RISE_SELECT;
		sfr_bit_i = b;
		sfr_bitpos_i = pos;
		sfr_wdata_i = d;
		pulse(sfr_wr_i);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] want);
		sfr_addr_i = a;
		tick(2);
		check({8'h00, sfr_rdata_o}, {8'h00, want});
	endtask : rd
	task automatic flags(input logic [23:0] s, input logic [23:0] c);
		request_flag_set_i = s;
		request_flag_clr_i = c;
		tick();
		request_flag_set_i = '0;
		request_flag_clr_i = '0;
	endtask : flags
	task automatic setpsw(input logic [7:0] v);
		psw_wdata_i = v;
		pulse(psw_wr_i);
	endtask : setpsw
	task automatic note(input logic [15:0] v, input int g);
		exp_q.push_back('{v, g});
	endtask : note
	function automatic logic [15:0] mvec(input int i);
		return via_pkg::VEC_MASK_BASE + 16'(2 * i);
	endfunction : mvec
	task automatic drain();
		for (int i = 0; i < 400 && (exp_q.size() != 0 || cpu_hold_o); i++) tick();
		check(16'(exp_q.size()), 16'h0000);
		check({15'h0000, cpu_hold_o}, 16'h0000);
	endtask : drain
	task automatic finish_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	// each acknowledge takes the oldest note
	always @(posedge clk_i) begin
		if (!rst_i && push_psw_o && cpu_hold_o) begin
			if (exp_q.size() == 0) begin
				check(vector_o, 16'hFFFF);
			end else begin
				cur = exp_q.pop_front();
				check(vector_o, cur.vec);
			end
			gap_cnt = 0;
		end else begin
			gap_cnt++;
		end
		if (vec_load_o) check(16'(gap_cnt), 16'(cur.gap));
	end

	// run is about 420 cycles; the limit is 8000 cycles
	initial begin
		#40000;
		n_errors++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		int p;
		void'($urandom(34));
		tick(8);
		rst_i = 1'b0;
		rd(via_pkg::ADDR_RISE_SELECT, 8'h00);
		rd(via_pkg::ADDR_FALL_SELECT, 8'h00);
		d = 8'($urandom());
		wr(1'b0, 1'b0, 3'h0, d);
		rd(via_pkg::ADDR_RISE_SELECT, d & 8'h1F);
		wr(1'b1, 1'b1, 3'h3, 8'h01);
		rd(via_pkg::ADDR_FALL_SELECT, 8'h08);
		rd(16'hFF4A, 8'h00);
		for (int m = 0; m < 4; m++) begin
			p = $urandom_range(4);
			wr(1'b0, 1'b0, 3'h0, 8'(m[1]) << p);
			wr(1'b1, 1'b0, 3'h0, 8'(m[0]) << p);
			external_irq_pin_i[p] = 1'b1;
			tick(8);
			check(16'(request_flag_o[p]), 16'(m[1]));
			flags('0, 24'(1) << p);
			external_irq_pin_i[p] = 1'b0;
			tick(8);
			check(16'(request_flag_o[p]), 16'(m[0]));
			flags('0, 24'(1) << p);
		end
		priority_flag_i = 24'hFFFFF7;
		mask_flag_i = 24'hFFFF73;
		slow = 1'b1;
		irq_src_i[7] = 1'b1;
		flags(24'h00020C, '0);
		irq_src_i[7] = 1'b0;
		tick(40);
		note(mvec(3), 5);
		setpsw(8'h82);
		drain();
		check(16'(stack_data_o), 16'h0082);
		slow = 1'b0;
		check(16'(program_status_word_o & 8'h82), 16'h0000);
		setpsw(8'h80);
		tick(40);
		note(mvec(2), 6);
		setpsw(8'h82);
		drain();
		check(16'(program_status_word_o & 8'h82), 16'h0002);
		note(mvec(7), 6);
		setpsw(8'h82);
		drain();
		check(request_flag_o[15:0], 16'h0200);
		note(via_pkg::VEC_BRK, 5);
		setpsw(8'h82);
		pulse(break_instruction_i);
		drain();
		check(16'(program_status_word_o), 16'h0002);
		stack_data_i = 8'h82;
		pulse(return_from_break_i);
		tick(2);
		check(16'(program_status_word_o), 16'h0082);
		pulse(push_psw_i);
		tick(3);
		check(16'(stack_data_o), 16'h0082);
		stack_data_i = 8'h02;
		pulse(pop_psw_i);
		tick(2);
		check(16'(program_status_word_o), 16'h0002);
		note(via_pkg::VEC_NMI, 5);
		note(via_pkg::VEC_NMI, 5);
		note(mvec(3), 5);
		setpsw(8'h82);
		nmi_req_i = 1'b1;
		flags(24'h000008, '0);
		nmi_req_i = 1'b0;
		tick(20);
		check(16'(program_status_word_o & 8'h82), 16'h0000);
		repeat (2) begin
			pulse(nmi_req_i);
			tick(4);
		end
		tick(30);
		check(16'(exp_q.size()), 16'h0002);
		pulse(return_from_irq_i);
		tick(30);
		check(16'(exp_q.size()), 16'h0001);
		stack_data_i = 8'h82;
		pulse(return_from_irq_i);
		drain();
		tick(40);
		finish_test();
	end
endmodule : testbench

// [via_ack.sv]
// interrupt acknowledge logic: edge select, request flags, psw, stacking
// Contract
// R1 - Reset clears the rising and falling edge select registers to zero.
// R2 - Select pair per pin: 00 off, 01 falling, 10 rising, 11 both edges.
// R3 - Select registers read and written at their addresses, by bit or byte.
// R4 - Reset loads the status word with 02H.
// R5 - Every vectored acknowledge or break pushes the status word and clears enable.
// R6 - Maskable acknowledge copies the source priority flag into in-service priority.
// R7 - Returns and pop restore the status word; push-status pushes it.
// R8 - In-service 0 blocks low priority; enable 1 allows acknowledge, 0 blocks.
// R9 - Non-maskable ignores enable and priority and beats every other source.
// R10 - Non-maskable acknowledge pushes, clears enable and in-service, loads its vector.
// R11 - Non-maskable during its service waits for return plus one instruction.
// R12 - Repeated non-maskable requests during service collapse into one pending.
// R13 - Maskable source eligible only with request flag 1 and mask flag 0.
// R14 - Acknowledge needs enable set; low priority refused while in-service is zero.
// R15 - Latency 7 to 32 clocks high priority, 8 to 33 low priority.
// R16 - Longest latency when a divide starts; divide completes before acknowledge.
// R17 - Simultaneous requests: high priority first, then fixed default order.
// R18 - Untaken requests stay pending and are taken once conditions permit.
// R19 - Maskable: push status, push counter, clear enable, set priority, branch.
// R20 - Break always interrupts: push, clear enable, vector 003EH, return by break-return.
// R21 - Request flag set on its event, cleared on acknowledge and reset.
// R22 - Priority flag 0 selects high level, 1 selects low level.
// R23 - Pins synchronised; a selected edge sets the request flag once.
`timescale 1ns/100ps
module via_ack #(
	parameter int NUM_PINS = via_pkg::SELECT_BITS,
	parameter int NUM_SRC = 24
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// special function register access from the cpu
	input wire logic [15:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_bit_i,
	input wire logic [2:0] sfr_bitpos_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// interrupt sources
	input wire logic [NUM_PINS-1:0] external_irq_pin_i,
	input wire logic [NUM_SRC-1:0] irq_src_i,
	input wire logic nmi_req_i,
	// request, mask and priority flags
	input wire logic [NUM_SRC-1:0] request_flag_set_i,
	input wire logic [NUM_SRC-1:0] request_flag_clr_i,
	input wire logic [NUM_SRC-1:0] mask_flag_i,
	input wire logic [NUM_SRC-1:0] priority_flag_i,
	output logic [NUM_SRC-1:0] request_flag_o,
	// instruction sequencer
	input wire logic instr_boundary_i,
	input wire logic break_instruction_i,
	input wire logic return_from_irq_i,
	input wire logic return_from_break_i,
	input wire logic pop_psw_i,
	input wire logic push_psw_i,
	input wire logic [7:0] stack_data_i,
	input wire logic psw_wr_i,
	input wire logic [7:0] psw_wdata_i,
	// status word and stacking
	output logic [7:0] program_status_word_o,
	output logic cpu_hold_o,
	output logic push_psw_o,
	output logic push_pc_o,
	output logic [7:0] stack_data_o,
	output logic vec_load_o,
	output logic [15:0] vector_o,
	output logic nmi_active_o
);

	// ----------------------------------------------------------------
	// edge select registers
	// ----------------------------------------------------------------
	logic [NUM_PINS-1:0] rise_select_reg;
	logic [NUM_PINS-1:0] fall_select_reg;
	logic [7:0] next_rise;
	logic [7:0] next_fall;
	logic [7:0] rise_byte;
	logic [7:0] fall_byte;

	always_comb begin
		rise_byte = '0;
		fall_byte = '0;
		rise_byte[NUM_PINS-1:0] = rise_select_reg;
		fall_byte[NUM_PINS-1:0] = fall_select_reg;
		next_rise = rise_byte;
		next_fall = fall_byte;
		if (sfr_bit_i) begin
			next_rise[sfr_bitpos_i] = sfr_wdata_i[0]; // R3
			next_fall[sfr_bitpos_i] = sfr_wdata_i[0]; // R3
		end else begin
			next_rise = sfr_wdata_i;
			next_fall = sfr_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rise_select_reg <= NUM_PINS'(via_pkg::RISE_SELECT_RESET); // R1
			fall_select_reg <= NUM_PINS'(via_pkg::FALL_SELECT_RESET); // R1
		end else if (sfr_wr_i) begin
			if (sfr_addr_i == via_pkg::ADDR_RISE_SELECT) begin
				rise_select_reg <= next_rise[NUM_PINS-1:0]; // R3
			end else if (sfr_addr_i == via_pkg::ADDR_FALL_SELECT) begin
				fall_select_reg <= next_fall[NUM_PINS-1:0]; // R3
			end
		end
	end

	// read data registered; unused upper bits and other addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_addr_i == via_pkg::ADDR_RISE_SELECT) begin
			sfr_rdata_o <= rise_byte; // R3
		end else if (sfr_addr_i == via_pkg::ADDR_FALL_SELECT) begin
			sfr_rdata_o <= fall_byte; // R3
		end else begin
			sfr_rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// external pins
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] pin_event;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_pin
			if (gi < NUM_PINS) begin : g_used
				via_edge_detect u_edge (
					.clk_i(clk_i),
					.rst_i(rst_i),
					.pin_i(external_irq_pin_i[gi]),
					.rise_select_bit_i(rise_select_reg[gi]),
					.fall_select_bit_i(fall_select_reg[gi]),
					.edge_o(pin_event[gi])
				);
			end else begin : g_none
				assign pin_event[gi] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	via_pkg::via_state_e state;
	via_pkg::via_kind_e kind;
	logic [5:0] seq_cnt;
	logic [5:0] seq_tgt;
	logic [1:0] ret_hold;
	logic nmi_pend;
	logic [7:0] program_status_word;

	// ----------------------------------------------------------------
	// selection
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] eligible;
	logic [NUM_SRC-1:0] elig_hi;
	logic [NUM_SRC-1:0] elig_lo;
	logic hi_found;
	logic lo_found;
	logic [4:0] hi_idx;
	logic [4:0] lo_idx;
	logic take_nmi;
	logic take_brk;
	logic take_mask;
	logic [4:0] take_idx;
	logic take_prio;
	logic idle_ok;

	assign eligible = request_flag_o & ~mask_flag_i; // R13
	assign elig_hi = eligible & ~priority_flag_i; // R22
	assign elig_lo = eligible & priority_flag_i; // R22

	// lowest index wins within a level
	always_comb begin
		hi_found = 1'b0;
		lo_found = 1'b0;
		hi_idx = 5'h00;
		lo_idx = 5'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (elig_hi[i]) begin
				hi_found = 1'b1;
				hi_idx = 5'(i); // R17
			end
			if (elig_lo[i]) begin
				lo_found = 1'b1;
				lo_idx = 5'(i); // R17
			end
		end
	end

	// nmi and maskable decisions only at an instruction boundary, so a divide finishes first
	assign idle_ok = (state == via_pkg::ST_IDLE) && (ret_hold == 2'b00);
	assign take_nmi = idle_ok && instr_boundary_i && (nmi_pend && !nmi_active_o); // R9 R11 R16
	assign take_brk = (state == via_pkg::ST_IDLE) && break_instruction_i && !take_nmi; // R20
	assign take_mask = idle_ok && instr_boundary_i && !take_nmi && !break_instruction_i
		&& program_status_word[via_pkg::PSW_IE_BIT] && !nmi_active_o
		&& (hi_found || (lo_found && program_status_word[via_pkg::PSW_ISP_BIT])); // R8 R14 R16 R18
	assign take_idx = hi_found ? hi_idx : lo_idx; // R17
	assign take_prio = !hi_found; // R17

	// ----------------------------------------------------------------
	// request flags: set wins over any clear in the same cycle
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] ack_clr;

	always_comb begin
		ack_clr = '0;
		if (take_mask) begin
			ack_clr[take_idx] = 1'b1; // R21
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			request_flag_o <= '0; // R21
		end else begin
			request_flag_o <= (request_flag_o & ~request_flag_clr_i & ~ack_clr)
				| irq_src_i | pin_event | request_flag_set_i; // R18 R21 R23
		end
	end

	// ----------------------------------------------------------------
	// non-maskable tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_pend <= 1'b0;
		end else if (nmi_req_i) begin
			nmi_pend <= 1'b1; // R12
		end else if (take_nmi) begin
			nmi_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_active_o <= 1'b0;
		end else if (take_nmi) begin
			nmi_active_o <= 1'b1;
		end else if (return_from_irq_i) begin
			nmi_active_o <= 1'b0; // R11
		end
	end

	// the return and one following main instruction run before any new acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ret_hold <= 2'b00;
		end else if (return_from_irq_i || return_from_break_i) begin
			ret_hold <= 2'b10; // R11
		end else if (instr_boundary_i && ret_hold != 2'b00) begin
			ret_hold <= ret_hold - 2'b01;
		end
	end

	// ----------------------------------------------------------------
	// program status word
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			program_status_word <= via_pkg::PSW_RESET; // R4
		end else if (take_nmi) begin
			program_status_word[via_pkg::PSW_IE_BIT] <= 1'b0; // R5 R10
			program_status_word[via_pkg::PSW_ISP_BIT] <= 1'b0; // R10
		end else if (take_mask) begin
			program_status_word[via_pkg::PSW_IE_BIT] <= 1'b0; // R5 R19
			program_status_word[via_pkg::PSW_ISP_BIT] <= priority_flag_i[take_idx]; // R6 R19
		end else if (take_brk) begin
			program_status_word[via_pkg::PSW_IE_BIT] <= 1'b0; // R5 R20
		end else if (return_from_irq_i || return_from_break_i || pop_psw_i) begin
			program_status_word <= stack_data_i; // R7
		end else if (psw_wr_i) begin
			program_status_word <= psw_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			program_status_word_o <= via_pkg::PSW_RESET;
		end else begin
			program_status_word_o <= program_status_word;
		end
	end

	// ----------------------------------------------------------------
	// stacking and vectoring sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= via_pkg::ST_IDLE;
			kind <= via_pkg::KIND_MASK;
			seq_cnt <= 6'h00;
			seq_tgt <= via_pkg::SEQ_TGT_HI;
			vector_o <= 16'h0000;
		end else begin
			case (state)
				via_pkg::ST_IDLE: begin
					seq_cnt <= 6'h01;
					if (take_nmi) begin
						state <= via_pkg::ST_SAVE_PSW;
						kind <= via_pkg::KIND_NMI;
						seq_tgt <= via_pkg::SEQ_TGT_HI;
						vector_o <= via_pkg::VEC_NMI; // R10
					end else if (take_brk) begin
						state <= via_pkg::ST_SAVE_PSW;
						kind <= via_pkg::KIND_BRK;
						seq_tgt <= via_pkg::SEQ_TGT_HI;
						vector_o <= via_pkg::VEC_BRK; // R20
					end else if (take_mask) begin
						state <= via_pkg::ST_SAVE_PSW;
						kind <= via_pkg::KIND_MASK;
						seq_tgt <= take_prio ? via_pkg::SEQ_TGT_LO : via_pkg::SEQ_TGT_HI; // R15
						vector_o <= via_pkg::VEC_MASK_BASE + {10'h000, take_idx, 1'b0}; // R19
					end
				end
				via_pkg::ST_SAVE_PSW: begin
					seq_cnt <= seq_cnt + 6'h01;
					state <= via_pkg::ST_SAVE_PC; // R19
				end
				via_pkg::ST_SAVE_PC: begin
					seq_cnt <= seq_cnt + 6'h01;
					state <= via_pkg::ST_WAIT;
				end
				via_pkg::ST_WAIT: begin
					seq_cnt <= seq_cnt + 6'h01;
					if (seq_cnt == seq_tgt - 6'h01) begin
						state <= via_pkg::ST_JUMP; // R15
					end
				end
				via_pkg::ST_JUMP: begin
					state <= via_pkg::ST_IDLE;
				end
				default: begin
					state <= via_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registered strobes toward the sequencer
	// ----------------------------------------------------------------
	logic start;

	assign start = take_nmi || take_brk || take_mask;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			push_psw_o <= 1'b0;
			push_pc_o <= 1'b0;
			stack_data_o <= 8'h00;
			vec_load_o <= 1'b0;
			cpu_hold_o <= 1'b0;
		end else begin
			push_psw_o <= start || (push_psw_i && state == via_pkg::ST_IDLE); // R5 R7
			push_pc_o <= (state == via_pkg::ST_SAVE_PSW); // R10 R19 R20
			if (start || (push_psw_i && state == via_pkg::ST_IDLE)) begin
				stack_data_o <= program_status_word; // R5 R7
			end
			vec_load_o <= (state == via_pkg::ST_WAIT) && (seq_cnt == seq_tgt - 6'h01); // R15
			if (start) begin
				cpu_hold_o <= 1'b1;
			end else if (state == via_pkg::ST_WAIT && seq_cnt == seq_tgt - 6'h01) begin
				cpu_hold_o <= 1'b0;
			end
		end
	end

endmodule : via_ack

// [via_ack_checker.sv]
// port-level assertions for the interrupt acknowledge block
`timescale 1ns/100ps
module via_ack_checker #(
	parameter int NUM_PINS = 5,
	parameter int NUM_SRC = 24
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register read
	input wire logic [15:0] sfr_addr_i,
	input wire logic [7:0] sfr_rdata_o,
	// acknowledge side
	input wire logic [NUM_SRC-1:0] request_flag_o,
	input wire logic [7:0] program_status_word_o,
	input wire logic cpu_hold_o,
	input wire logic push_psw_o,
	input wire logic push_pc_o,
	input wire logic vec_load_o,
	input wire logic [15:0] vector_o,
	input wire logic nmi_active_o
);
	logic ack;
	logic nmi_vec;
	logic mask_vec;
	logic [4:0] idx;
	// push-status pushes without holding the cpu
	assign ack = push_psw_o && cpu_hold_o;
	assign nmi_vec = vector_o == via_pkg::VEC_NMI;
	assign mask_vec = !nmi_vec && vector_o != via_pkg::VEC_BRK;
	assign idx = 5'((vector_o - via_pkg::VEC_MASK_BASE) >> 1);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_stack;
		ack ##1 push_pc_o;
	endsequence
	sequence s_jump;
		##[4:5] vec_load_o;
	endsequence
	chk_reset_state:
		assert property ($fell(rst_i) |-> program_status_word_o == via_pkg::PSW_RESET
			&& request_flag_o == '0) else $error("state after reset wrong");
	chk_stack_order:
		assert property (ack |-> s_stack) else $error("counter not pushed after status");
	chk_jump_time:
		assert property (s_stack |-> s_jump) else $error("vector load out of time");
	chk_hold_span:
		assert property (ack |-> cpu_hold_o [*5]) else $error("cpu released too soon");
	chk_vector_held:
		assert property (ack |=> $stable(vector_o) [*5]) else $error("vector moved");
	chk_enable_cleared:
		assert property (ack |-> ##2 !program_status_word_o[via_pkg::PSW_IE_BIT])
			else $error("enable not cleared");
	chk_nmi_priority:
		assert property (ack && nmi_vec |-> ##2 !program_status_word_o[via_pkg::PSW_ISP_BIT])
			else $error("priority bit kept on nmi");
	chk_flag_cleared:
		assert property (ack && mask_vec |-> !request_flag_o[idx]) else $error("flag kept");
	chk_unmapped_read:
		assert property (sfr_addr_i != via_pkg::ADDR_RISE_SELECT
			&& sfr_addr_i != via_pkg::ADDR_FALL_SELECT |=> sfr_rdata_o == 8'h00)
			else $error("unmapped read nonzero");
	chk_nmi_vector:
		assert property ($rose(nmi_active_o) |-> nmi_vec) else $error("nmi without its vector");
endmodule : via_ack_checker

bind via_ack via_ack_checker #(.NUM_PINS(NUM_PINS), .NUM_SRC(NUM_SRC)) u_via_ack_checker (
	.clk_i, .rst_i, .sfr_addr_i, .sfr_rdata_o, .request_flag_o, .program_status_word_o,
	.cpu_hold_o, .push_psw_o, .push_pc_o, .vec_load_o, .vector_o, .nmi_active_o
);

// [via_cpu_model.sv]
// instruction sequencer stand-in that paces instruction boundaries
`timescale 1ns/100ps
module via_cpu_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pacing and hold
	input wire logic slow_i,
	input wire logic cpu_hold_i,
	// sequencer
	output logic instr_boundary_o
);
	logic [5:0] cnt;
	// slow steps stand for a divide that must end before any acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i || cpu_hold_i) begin
			cnt <= 6'h00;
			instr_boundary_o <= 1'b0;
		end else begin
			cnt <= instr_boundary_o ? 6'h00 : cnt + 6'h01;
			instr_boundary_o <= cnt == (slow_i ? 6'h18 : 6'h02);
		end
	end
endmodule : via_cpu_model

// [via_edge_detect.sv]
// one external interrupt pin: synchroniser and edge selection
`timescale 1ns/100ps
module via_edge_detect (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pin and edge selection
	input wire logic pin_i,
	input wire logic rise_select_bit_i,
	input wire logic fall_select_bit_i,
	// one pulse per selected edge
	output logic edge_o
);

	// ----------------------------------------------------------------
	// three-stage synchroniser
	// ----------------------------------------------------------------
	logic sync1;
	logic sync2;
	logic sync3;
	logic level;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= pin_i;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// ----------------------------------------------------------------
	// accepted level and edge pulse
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level <= 1'b0;
			edge_o <= 1'b0;
		end else begin
			edge_o <= 1'b0;
			if (sync2 == sync3 && sync2 != level) begin
				level <= sync2;
				edge_o <= (sync2 & rise_select_bit_i) | (~sync2 & fall_select_bit_i); // R2 R23
			end
		end
	end

endmodule : via_edge_detect

// [via_pkg.sv]
// constants and types shared by the interrupt acknowledge block
package via_pkg;

	// ----------------------------------------------------------------
	// register addresses and layout
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_RISE_SELECT = 16'hFF48;
	localparam logic [15:0] ADDR_FALL_SELECT = 16'hFF49;
	localparam logic [7:0] RISE_SELECT_RESET = 8'h00;
	localparam logic [7:0] FALL_SELECT_RESET = 8'h00;
	localparam int SELECT_BITS = 5;

	// ----------------------------------------------------------------
	// program status word
	// ----------------------------------------------------------------
	localparam logic [7:0] PSW_RESET = 8'h02;
	localparam int PSW_IE_BIT = 7;
	localparam int PSW_ISP_BIT = 1;

	// ----------------------------------------------------------------
	// vector table
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_NMI = 16'h0004;
	localparam logic [15:0] VEC_MASK_BASE = 16'h0006;
	localparam logic [15:0] VEC_BRK = 16'h003E;

	// ----------------------------------------------------------------
	// latency in cpu clocks, request to start of servicing
	// ----------------------------------------------------------------
	localparam int LAT_MIN_HI_CLK = 7;
	localparam int LAT_MIN_LO_CLK = 8;
	localparam int LAT_MAX_HI_CLK = 32;
	localparam int LAT_MAX_LO_CLK = 33;
	localparam logic [5:0] SEQ_TGT_HI = 6'(LAT_MIN_HI_CLK - 1);
	localparam logic [5:0] SEQ_TGT_LO = 6'(LAT_MIN_LO_CLK - 1);

	// ----------------------------------------------------------------
	// sequencer types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SAVE_PSW,
		ST_SAVE_PC,
		ST_WAIT,
		ST_JUMP
	} via_state_e;

	typedef enum logic [1:0] {
		KIND_NMI,
		KIND_MASK,
		KIND_BRK
	} via_kind_e;

endpackage : via_pkg
